// *** rtl/spcfg_port.v ***
`timescale 1ns/1ps
`default_nettype none
`include "spcfg_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// one serial port: framing, packet accumulation, echo, highlight,
// multidrop slot, retry delay, route and modbus translation
module spcfg_port #(
  parameter [7:0]  DROP_DEF  = `SPCFG_DROP_P1,
  parameter [31:0] HUND_CYC  = `SPCFG_HUNDREDTH_CYC,
  parameter        PKT_DEPTH = 128
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // configuration levels
  input  wire        cfg_load,
  input  wire [7:0]  drop_in,
  input  wire [31:0] baud_in,
  input  wire [1:0]  parity_in,
  input  wire        data8_in,
  input  wire        stop2_in,
  input  wire [4:0]  buf_limit_in,
  input  wire [1:0]  drive_mode,
  input  wire        use_crc,
  input  wire        stream_mode,
  input  wire [7:0]  pkt_size,
  input  wire [15:0] pkt_time,
  input  wire        ctrl_term,
  input  wire        echo_en,
  input  wire        gateway_mode,
  input  wire        highlight_en,
  input  wire        multidrop,
  input  wire [7:0]  node_count,
  input  wire [7:0]  node_prio,
  input  wire [15:0] time_slice,
  input  wire [7:0]  fc_read_in,
  input  wire [7:0]  fc_write_in,
  input  wire [15:0] retry_time,
  input  wire [15:0] reg_bias,
  // route handling
  input  wire [7:0]  route_last,
  input  wire [7:0]  route_prev,
  input  wire        appendix_present,
  input  wire        replace_en,
  input  wire [7:0]  options,
  input  wire        single_thread,
  output reg  [1:0]  route_sel_ff,
  output reg  [7:0]  table_index_ff,
  output reg         reply_reverse_ff,
  // modbus translation
  input  wire        req_write,
  input  wire [15:0] src_reg,
  output reg  [7:0]  mb_func_ff,
  output reg  [15:0] mb_addr_ff,
  output reg         mb_addr_err_ff,
  // message traffic
  input  wire        tx_fail,
  input  wire        reply_start,
  input  wire        reply_end,
  input  wire [4:0]  bufs_used,
  output wire        buf_avail,
  output reg         retry_ok_ff,
  output reg         slot_ok_ff,
  output reg         cfg_err_ff,
  output reg  [7:0]  drop_ff,
  output reg         drv_en_ff,
  output reg         rx_en_ff,
  // packet out
  output reg         pkt_ready_ff,
  output reg  [7:0]  pkt_len_ff,
  input  wire [7:0]  pkt_rd_addr,
  output reg  [7:0]  pkt_rd_data_ff,
  // serial pins
  input  wire        rx_pin,
  output wire        tx_pin
);
  reg  [31:0] baud_ff;        // bit period in cycles
  reg  [1:0]  par_ff;         // parity choice
  reg         d8_ff;          // 8 data bits
  reg         s2_ff;          // 2 stop bits
  reg  [4:0]  buf_lim_ff;     // clamped buffer limit
  reg  [7:0]  fcr_ff;         // read function code
  reg  [7:0]  fcw_ff;         // write function code
  reg  [7:0]  mem [0:PKT_DEPTH-1]; // packet characters
  reg  [7:0]  cnt_ff;         // characters accumulated
  reg  [31:0] tick_ff;        // hundredth divider
  reg         hund_ff;        // hundredth pulse
  reg  [15:0] gap_ff;         // inter-character hundredths
  reg  [15:0] slot_ff;        // multidrop quiet hundredths
  reg  [15:0] retry_ff;       // retry wait hundredths
  reg  [2:0]  hl_ff;          // highlight chars left
  reg         hl_end_ff;      // trailing sequence
  wire [7:0]  rx_data;        // received character
  wire        rx_valid;       // character strobe
  wire        rx_perr;        // parity error
  wire        tx_busy;        // transmitter busy
  reg  [7:0]  tx_data;        // character to send
  reg         tx_go;          // start a send
  wire        flush;          // form a packet now
  wire [7:0]  size_eff;       // count, zero means one
  wire [16:0] addr_sum;       // bias arithmetic

  // highlight byte table: ESC [ 7 m / ESC [ 0 m
  function [7:0] hl_char;
    input [2:0] idx;
    input       fin;
    begin
      case (idx)
        3'h4:    hl_char = `SPCFG_ESC;
        3'h3:    hl_char = 8'h5B;
        3'h2:    hl_char = fin ? 8'h30 : 8'h37;
        default: hl_char = 8'h6D;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // configuration capture with defaults at reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      drop_ff    <= DROP_DEF;
      baud_ff    <= `SPCFG_BAUD_DEF;
      par_ff     <= `SPCFG_PAR_EVEN;
      d8_ff      <= 1'b1;
      s2_ff      <= 1'b0;
      buf_lim_ff <= `SPCFG_BUF_MAX;
      fcr_ff     <= `SPCFG_FC_READ_DEF;
      fcw_ff     <= `SPCFG_FC_WRITE_DEF;
    end else if (cfg_load) begin
      if (drop_in <= `SPCFG_DROP_MAX)
        drop_ff <= drop_in;
      baud_ff <= (baud_in == 32'h0000_0000) ? `SPCFG_BAUD_DEF : baud_in;
      par_ff  <= (parity_in == 2'h3) ? `SPCFG_PAR_EVEN : parity_in;
      d8_ff   <= data8_in;
      s2_ff   <= stop2_in;
      // clamp buffer limit into range
      buf_lim_ff <= (buf_limit_in < `SPCFG_BUF_MIN) ? `SPCFG_BUF_MIN :
                    (buf_limit_in > `SPCFG_BUF_MAX) ? `SPCFG_BUF_MAX : buf_limit_in;
      // only legal codes accepted
      if (fc_read_in >= 8'h01 && fc_read_in <= 8'h04)
        fcr_ff <= fc_read_in;
      if (fc_write_in == 8'h05 || fc_write_in == 8'h06 ||
          fc_write_in == 8'h0F || fc_write_in == 8'h10)
        fcw_ff <= fc_write_in;
    end
  end

  assign buf_avail = (bufs_used < buf_lim_ff);

  //////////////////////////////////////////////////////////////////////////////
  // framer instance
  spcfg_uart u_uart (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .baud_div    (baud_ff),
    .parity_sel  (par_ff),
    .data8       (d8_ff),
    .stop2       (s2_ff),
    .rx_pin      (rx_pin),
    .rx_data_ff  (rx_data),
    .rx_valid_ff (rx_valid),
    .rx_perr_ff  (rx_perr),
    .tx_data     (tx_data),
    .tx_start    (tx_go),
    .tx_busy     (tx_busy),
    .tx_pin_ff   (tx_pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  // hundredth-second enable divider
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_ff <= 32'h0000_0000;
      hund_ff <= 1'b0;
    end else begin
      hund_ff <= (tick_ff == HUND_CYC - 32'h0000_0001);
      tick_ff <= (tick_ff == HUND_CYC - 32'h0000_0001) ? 32'h0000_0000
                                                      : tick_ff + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // packet accumulation by size, gap or control character
  assign size_eff = (pkt_size == 8'h00) ? 8'h01 : pkt_size;
  assign flush = stream_mode && (cnt_ff != 8'h00) && !pkt_ready_ff &&
                 ((cnt_ff >= size_eff) ||
                  (gap_ff > pkt_time));

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff       <= 8'h00;
      gap_ff       <= 16'h0000;
      pkt_ready_ff <= 1'b0;
      pkt_len_ff   <= 8'h00;
    end else begin
      if (hund_ff && cnt_ff != 8'h00 && gap_ff != 16'hFFFF)
        gap_ff <= gap_ff + 16'h0001;
      if (pkt_ready_ff && reply_start)
        pkt_ready_ff <= 1'b0;                 // consumer takes packet
      if (flush) begin
        pkt_ready_ff <= 1'b1;
        pkt_len_ff   <= cnt_ff;
        cnt_ff       <= 8'h00;
        gap_ff       <= 16'h0000;
      end else if (stream_mode && rx_valid && !rx_perr && !pkt_ready_ff &&
                   cnt_ff < PKT_DEPTH) begin
        mem[cnt_ff[6:0]] <= rx_data;
        gap_ff <= 16'h0000;
        if (ctrl_term && rx_data < 8'h20) begin
          // control character closes message
          pkt_ready_ff <= 1'b1;
          pkt_len_ff   <= cnt_ff + 8'h01;
          cnt_ff       <= 8'h00;
        end else
          cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  // packet readback
  always @(posedge sys_clk) begin
    pkt_rd_data_ff <= mem[pkt_rd_addr[6:0]];
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit source: highlight then echo
  always @* begin
    tx_go   = 1'b0;
    tx_data = rx_data;
    if (!tx_busy && hl_ff != 3'h0) begin
      tx_go   = 1'b1;
      tx_data = hl_char(hl_ff, hl_end_ff);
    end else if (!tx_busy && echo_en && rx_valid) begin
      tx_go = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hl_ff     <= 3'h0;
      hl_end_ff <= 1'b0;
    end else if (gateway_mode && highlight_en && (reply_start || reply_end) &&
                 hl_ff == 3'h0) begin
      hl_ff     <= 3'h4;
      hl_end_ff <= reply_end;
    end else if (tx_go && hl_ff != 3'h0) begin
      hl_ff <= hl_ff - 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // multidrop slot and retry delay timers
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_ff     <= 16'h0000;
      slot_ok_ff  <= 1'b1;
      retry_ff    <= 16'h0000;
      retry_ok_ff <= 1'b1;
      cfg_err_ff  <= 1'b0;
    end else begin
      // quiet time since last character
      if (rx_valid)
        slot_ff <= 16'h0000;
      else if (hund_ff && slot_ff != 16'hFFFF)
        slot_ff <= slot_ff + 16'h0001;
      slot_ok_ff <= !multidrop || (!rx_valid && slot_ff >= time_slice);
      // node count and priority sanity
      cfg_err_ff <= multidrop && ((node_count < 8'h02) || (node_prio == 8'h00) ||
                                  (node_prio > node_count));
      // retry wait after failure
      if (tx_fail) begin
        retry_ff    <= (retry_time == 16'h0000) ? 16'h0000 : retry_time;
        retry_ok_ff <= (retry_time == 16'h0000);
      end else if (retry_ff != 16'h0000) begin
        if (hund_ff)
          retry_ff <= retry_ff - 16'h0001;
        retry_ok_ff <= 1'b0;
      end else
        retry_ok_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // line driver scheme: drive and receive enables
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      drv_en_ff <= 1'b1;
      rx_en_ff  <= 1'b1;
    end else begin
      case (drive_mode)
        `SPCFG_DRV_P2P: begin
          drv_en_ff <= 1'b1;
          rx_en_ff  <= 1'b1;
        end
        `SPCFG_DRV_FOUR: begin
          drv_en_ff <= tx_busy || tx_go;
          rx_en_ff  <= 1'b1;
        end
        `SPCFG_DRV_HALF: begin
          drv_en_ff <= tx_busy || tx_go;
          rx_en_ff  <= 1'b1;
        end
        default: begin
          drv_en_ff <= tx_busy || tx_go;
          rx_en_ff  <= !(tx_busy || tx_go);
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // route decision and modbus translation
  assign addr_sum = {1'b0, src_reg} + {1'b0, reg_bias} - 17'h0_0001;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      route_sel_ff     <= 2'h0;
      table_index_ff   <= 8'h00;
      reply_reverse_ff <= 1'b0;
      mb_func_ff       <= `SPCFG_FC_READ_DEF;
      mb_addr_ff       <= 16'h0000;
      mb_addr_err_ff   <= 1'b0;
    end else begin
      // 0 keep, 1 append, 2 replace, 3 table lookup
      if (options[`SPCFG_OPT_TABLE_BIT] && single_thread &&
          route_prev == `SPCFG_DROP_APPEND && route_last[7] == 1'b0) begin
        route_sel_ff     <= 2'h3;
        table_index_ff   <= route_last;
        reply_reverse_ff <= 1'b1;
      end else if (replace_en && appendix_present) begin
        route_sel_ff     <= 2'h2;
        reply_reverse_ff <= 1'b1;
      end else if (route_last == `SPCFG_DROP_APPEND && appendix_present) begin
        route_sel_ff     <= 2'h1;
        reply_reverse_ff <= 1'b0;
      end else begin
        route_sel_ff     <= 2'h0;
        reply_reverse_ff <= 1'b0;
      end
      mb_func_ff     <= req_write ? fcw_ff : fcr_ff;
      mb_addr_ff     <= addr_sum[15:0];
      mb_addr_err_ff <= (src_reg == 16'h0000) || (src_reg > `SPCFG_REG_MAX) ||
                        addr_sum[16];
    end
  end
endmodule // spcfg_port
`default_nettype wire

// *** rtl/spcfg_regs.vh ***
// Behaviour
// - drop numbers 000..199, unique per module
// - defaults: port one 2, port two 102
// - baud rate configurable, default 9600
// - even, odd or no parity; even default
// - 7/8 data bits, 1/2 stop bits
// - buffer limit 2..16, default 16
// - four selectable line driver schemes
// - block check character or crc frame check (neither is formed; use_crc is unused)
// - final drop 205 replaced by appendix
// - replacement uses appendix, reply route reversed
// - options bit two: 205,X uses table X (only with single_thread set and X below 128)
// - packet formed at character count, default 128
// - inter-character gap timeout forms packet
// - control character ends packet early
// - echo retransmits each received character (skipped while the transmitter is busy or a highlight sequence is pending)
// - highlight sequences around gateway replies
// - multidrop: nodes at least 2, unique priority
// - multidrop waits time slice after last character
// - read function code 1..4, default 4
// - write function code 5,6,15,16, default 16
// - retry delay after failure, default 100
// - register address = source + offset - 1
`ifndef SPCFG_REGS_VH
`define SPCFG_REGS_VH
`define SPCFG_CLK_HZ        50000000
`define SPCFG_HUNDREDTH_CYC (`SPCFG_CLK_HZ / 100)
`define SPCFG_DROP_MAX      8'h00C7
`define SPCFG_DROP_P1       8'h0002
`define SPCFG_DROP_P2       8'h0066
`define SPCFG_DROP_APPEND   8'h00CD
`define SPCFG_BAUD_DEF      32'h0000_2580
`define SPCFG_PAR_NONE      2'h0
`define SPCFG_PAR_EVEN      2'h1
`define SPCFG_PAR_ODD       2'h2
`define SPCFG_BUF_MIN       5'h02
`define SPCFG_BUF_MAX       5'h10
`define SPCFG_PKT_SIZE_DEF  8'h0080
`define SPCFG_PKT_TIME_DEF  16'h0064
`define SPCFG_RETRY_DEF     16'h0064
`define SPCFG_FC_READ_DEF   8'h0004
`define SPCFG_FC_WRITE_DEF  8'h0010
`define SPCFG_BIAS_DEF      16'h0001
`define SPCFG_REG_MAX       16'h2000
`define SPCFG_DRV_P2P       2'h0
`define SPCFG_DRV_FOUR      2'h1
`define SPCFG_DRV_HALF      2'h2
`define SPCFG_DRV_TWO       2'h3
`define SPCFG_CR            8'h000D
`define SPCFG_ESC           8'h001B
`define SPCFG_OPT_TABLE_BIT 2
`endif

// *** rtl/spcfg_uart.v ***
`timescale 1ns/1ps
`default_nettype none
`include "spcfg_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// character framer: 7/8 data, parity, 1/2 stop, one port
module spcfg_uart (
  // clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // configuration
  input  wire [31:0] baud_div,
  input  wire [1:0]  parity_sel,
  input  wire        data8,
  input  wire        stop2,
  // receive
  input  wire        rx_pin,
  output reg  [7:0]  rx_data_ff,
  output reg         rx_valid_ff,
  output reg         rx_perr_ff,
  // transmit
  input  wire [7:0]  tx_data,
  input  wire        tx_start,
  output wire        tx_busy,
  output reg         tx_pin_ff
);
  reg  [1:0]  rx_sync_ff;   // two-flop synchroniser
  reg  [31:0] rx_cnt_ff;    // receive bit timer
  reg  [3:0]  rx_bit_ff;    // receive bit index
  reg  [9:0]  rx_sh_ff;     // receive shifter
  reg         rx_act_ff;    // receiving a character
  reg  [31:0] tx_cnt_ff;    // transmit bit timer
  reg  [3:0]  tx_left_ff;   // bits still to send
  reg  [11:0] tx_sh_ff;     // transmit shifter
  wire [3:0]  nbits;        // data+parity bits
  wire        tx_par;       // transmit parity bit
  wire [9:0]  rx_al;        // aligned shifter

  assign nbits   = (data8 ? 4'h8 : 4'h7) + ((parity_sel != `SPCFG_PAR_NONE) ? 4'h1 : 4'h0);
  assign tx_par  = (data8 ? ^tx_data : ^tx_data[6:0]) ^ (parity_sel == `SPCFG_PAR_ODD);
  assign tx_busy = (tx_left_ff != 4'h0);
  assign rx_al   = rx_sh_ff >> (4'hA - nbits);

  // receiver: mid-bit sampling
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync_ff  <= 2'h3;
      rx_cnt_ff   <= 32'h0000_0000;
      rx_bit_ff   <= 4'h0;
      rx_sh_ff    <= 10'h000;
      rx_act_ff   <= 1'b0;
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      rx_perr_ff  <= 1'b0;
    end else begin
      rx_sync_ff  <= {rx_sync_ff[0], rx_pin};
      rx_valid_ff <= 1'b0;
      if (!rx_act_ff) begin
        // start bit: wait half a bit
        if (!rx_sync_ff[1]) begin
          rx_act_ff <= 1'b1;
          rx_cnt_ff <= baud_div >> 1;
          rx_bit_ff <= 4'h0;
        end
      end else if (rx_cnt_ff != 32'h0000_0000) begin
        rx_cnt_ff <= rx_cnt_ff - 32'h0000_0001;
      end else begin
        rx_cnt_ff <= baud_div;
        if (rx_bit_ff == nbits + 4'h1) begin
          // stop bit sampled: deliver
          rx_act_ff   <= 1'b0;
          rx_valid_ff <= rx_sync_ff[1];
          rx_data_ff  <= data8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
          rx_perr_ff  <= (parity_sel != `SPCFG_PAR_NONE) &&
                         ((^rx_sh_ff[9:1]) != (parity_sel == `SPCFG_PAR_ODD));
        end else begin
          if (rx_bit_ff != 4'h0)
            rx_sh_ff <= {rx_sync_ff[1], rx_sh_ff[9:1]} >> 0;
          rx_bit_ff <= rx_bit_ff + 4'h1;
        end
      end
      // clear shifter after stop bit; data bits landed at [9-nbits+1..]
      if (rx_act_ff && rx_cnt_ff == 32'h0000_0000 && rx_bit_ff == nbits + 4'h1)
        rx_sh_ff <= 10'h000;
    end
  end

  // transmitter: start, data, parity, stop bits
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_cnt_ff  <= 32'h0000_0000;
      tx_left_ff <= 4'h0;
      tx_sh_ff   <= 12'hFFF;
      tx_pin_ff  <= 1'b1;
    end else if (tx_left_ff == 4'h0) begin
      tx_pin_ff <= 1'b1;
      if (tx_start) begin
        // frame length: start + bits + stops
        tx_left_ff <= 4'h1 + nbits + (stop2 ? 4'h2 : 4'h1);
        tx_cnt_ff  <= baud_div;
        tx_pin_ff  <= 1'b0;
        if (data8)
          tx_sh_ff <= {2'h3, (parity_sel == `SPCFG_PAR_NONE) ? 1'b1 : tx_par, tx_data, 1'b0};
        else
          tx_sh_ff <= {3'h7, (parity_sel == `SPCFG_PAR_NONE) ? 1'b1 : tx_par, tx_data[6:0], 1'b0};
      end
    end else if (tx_cnt_ff != 32'h0000_0000) begin
      tx_cnt_ff <= tx_cnt_ff - 32'h0000_0001;
    end else begin
      tx_cnt_ff  <= baud_div;
      tx_sh_ff   <= {1'b1, tx_sh_ff[11:1]};
      tx_pin_ff  <= tx_sh_ff[1];
      tx_left_ff <= tx_left_ff - 4'h1;
    end
  end
endmodule // spcfg_uart
`default_nettype wire

// *** testbench/spcfg_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// attached serial device: frames characters into the port
module spcfg_dev_model (
  // clock
  input  wire logic        sys_clk,
  // bit period in clocks, set to match the port
  input  wire logic [31:0] bit_cyc,
  // line into the port, idles high
  output var  logic        line
);
  initial line = 1'b1;
  // one bit held a full bit period
  task automatic put_bit(input logic b);
    line = b;
    repeat (bit_cyc + 32'h0000_0001) @(posedge sys_clk);
    #1;
  endtask
  // start, 8 data lsb first, even parity, one stop at the port's rate
  task automatic send(input logic [7:0] c);
    int i;
    @(posedge sys_clk);
    #1;
    put_bit(1'b0);
    for (i = 0; i < 8; i++) put_bit(c[i]);
    put_bit(^c);
    put_bit(1'b1);
  endtask
endmodule // spcfg_dev_model
`default_nettype wire

// *** testbench/spcfg_port_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// watches one port: config, route, modbus, retry, packet
module spcfg_port_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // single-bit controls and flags
  input wire logic        cfg_load, tx_fail, reply_start, pkt_ready_ff, retry_ok_ff,
  input wire logic        mb_addr_err_ff, appendix_present, replace_en, single_thread,
  // wide values
  input wire logic [7:0]  drop_in, drop_ff, mb_func_ff, route_last, route_prev,
  input wire logic [7:0]  options, table_index_ff,
  input wire logic [15:0] src_reg, reg_bias, mb_addr_ff, retry_time,
  input wire logic [1:0]  route_sel_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  drop_take_a: assert property (
    cfg_load && drop_in <= 8'hC7 |=> drop_ff == $past(drop_in)) else $error("drop not taken");
  drop_keep_a: assert property (
    cfg_load && drop_in > 8'hC7 |=> drop_ff == $past(drop_ff)) else $error("bad drop taken");
  func_legal_a: assert property (
    mb_func_ff inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10})
    else $error("illegal function code");
  addr_calc_a: assert property (
    src_reg != 16'h0000 && src_reg <= 16'h2000 |=>
    mb_addr_ff == $past(src_reg) + $past(reg_bias) - 16'h0001 && !mb_addr_err_ff)
    else $error("modbus address wrong");
  addr_err_a: assert property (
    src_reg == 16'h0000 || src_reg > 16'h2000 |=> mb_addr_err_ff) else $error("range not flagged");
  route_append_a: assert property (
    route_last == 8'hCD && appendix_present && !replace_en |=> route_sel_ff == 2'h1)
    else $error("appendix not used");
  route_keep_a: assert property (
    !appendix_present && !options[2] |=> route_sel_ff == 2'h0) else $error("route changed");
  route_replace_a: assert property (
    replace_en && appendix_present && !options[2] && route_last != 8'hCD |=> route_sel_ff == 2'h2)
    else $error("route not replaced");
  route_table_a: assert property (
    options[2] && single_thread && route_prev == 8'hCD && route_last < 8'h80 && !replace_en
    |=> route_sel_ff == 2'h3 && table_index_ff == $past(route_last)) else $error("table miss");
  retry_low_a: assert property (
    tx_fail && retry_time != 16'h0000 |=> !retry_ok_ff) else $error("retry not held off");
  pkt_hold_a: assert property (
    pkt_ready_ff && !reply_start |=> pkt_ready_ff) else $error("packet dropped early");
endmodule // spcfg_port_asserts

bind spcfg_port spcfg_port_asserts u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .cfg_load(cfg_load), .tx_fail(tx_fail),
  .reply_start(reply_start), .pkt_ready_ff(pkt_ready_ff), .retry_ok_ff(retry_ok_ff),
  .mb_addr_err_ff(mb_addr_err_ff), .appendix_present(appendix_present),
  .replace_en(replace_en), .single_thread(single_thread), .drop_in(drop_in),
  .drop_ff(drop_ff), .mb_func_ff(mb_func_ff), .route_last(route_last),
  .route_prev(route_prev), .options(options), .table_index_ff(table_index_ff),
  .src_reg(src_reg), .reg_bias(reg_bias), .mb_addr_ff(mb_addr_ff), .route_sel_ff(route_sel_ff),
  .retry_time(retry_time));
`default_nettype wire

// *** testbench/spcfg_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for one port
module spcfg_port_tb_top;
  logic        sys_clk, arst_n, cfg_load, data8_in, stop2_in, use_crc, stream_mode, ctrl_term;
  logic        echo_en, gateway_mode, highlight_en, multidrop, appendix_present, replace_en;
  logic        single_thread, req_write, tx_fail, reply_start, reply_end, reply_reverse_ff;
  logic        mb_addr_err_ff, buf_avail, retry_ok_ff, slot_ok_ff, cfg_err_ff, drv_en_ff;
  logic        rx_en_ff, pkt_ready_ff, rx_pin, tx_pin;
  logic [31:0] baud_in;
  logic [1:0]  parity_in, drive_mode, route_sel_ff;
  logic [4:0]  buf_limit_in, bufs_used;
  logic [7:0]  drop_in, pkt_size, node_count, node_prio, fc_read_in, fc_write_in, route_last;
  logic [7:0]  route_prev, options, table_index_ff, mb_func_ff, drop_ff, pkt_len_ff;
  logic [7:0]  pkt_rd_addr, pkt_rd_data_ff;
  logic [15:0] pkt_time, time_slice, retry_time, reg_bias, src_reg, mb_addr_ff;
  int          failures, cmp_count, cyc;
  // short hundredth
  spcfg_port #(.HUND_CYC(32'h0000_000A)) uut (.*);
  spcfg_dev_model dev (.sys_clk(sys_clk), .bit_cyc(baud_in), .line(rx_pin));
  always #10 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // config taken on a clock edge while cfg_load is high
  task automatic load;
    cfg_load = 1'b1;
    step(1);
    cfg_load = 1'b0;
    step(1);
  endtask
  task automatic t_cfg;
    logic [7:0] wr [4];
    wr = '{8'h05, 8'h06, 8'h0F, 8'h10};
    chk(drop_ff, 32'h0000_0002);
    chk(mb_func_ff, 32'h0000_0004);
    drop_in = 8'hC7;
    load;
    chk(drop_ff, 32'h0000_00C7);
    drop_in = 8'hC8;
    load;
    chk(drop_ff, 32'h0000_00C7);
    for (int i = 1; i <= 4; i++) begin
      fc_read_in = i[7:0];
      load;
      chk(mb_func_ff, i);
    end
    req_write = 1'b1;
    for (int i = 0; i < 4; i++) begin
      fc_write_in = wr[i];
      load;
      chk(mb_func_ff, {24'h0, wr[i]});
    end
    fc_write_in = 8'h07;
    load;
    chk(mb_func_ff, 32'h0000_0010);
    req_write = 1'b0;
  endtask
  // bias arithmetic and range flag
  task automatic t_addr;
    logic [15:0] s [5], b [5], e [5];
    s = '{16'h0001, 16'h000A, 16'h2000, 16'h0000, 16'h2001};
    b = '{16'h0001, 16'h4E21, 16'h0000, 16'h0001, 16'h0001};
    e = '{16'h0001, 16'h4E2A, 16'h1FFF, 16'h0000, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      src_reg = s[i];
      reg_bias = b[i];
      step(2);
      chk(mb_addr_err_ff, i > 2);
      if (i < 3) chk(mb_addr_ff, e[i]);
    end
  endtask
  // append, keep, replace, table lookup
  task automatic t_route;
    logic [7:0] l [4], p [4], o [4];
    logic [1:0] sel [4];
    logic [3:0] f [4];
    l = '{8'hCD, 8'hCD, 8'h09, 8'h28};
    p = '{8'h05, 8'h05, 8'h03, 8'hCD};
    o = '{8'h00, 8'h00, 8'h00, 8'h04};
    f = '{4'h8, 4'h0, 4'hC, 4'h1};
    sel = '{2'h1, 2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 4; i++) begin
      {route_last, route_prev, options} = {l[i], p[i], o[i]};
      {appendix_present, replace_en, single_thread} = {f[i][3], f[i][2], f[i][0]};
      step(2);
      chk(route_sel_ff, sel[i]);
      chk(reply_reverse_ff, sel[i][1]);
    end
    chk(table_index_ff, 32'h0000_0028);
  endtask
  // await packet, check it, release it
  task automatic t_pkt(input logic [7:0] n, input logic [7:0] b0);
    for (int i = 0; i < 3000 && pkt_ready_ff !== 1'b1; i++) step(1);
    chk(pkt_len_ff, n);
    pkt_rd_addr = 8'h00;
    step(2);
    chk(pkt_rd_data_ff, b0);
    reply_start = 1'b1;
    step(1);
    reply_start = 1'b0;
    step(1);
    chk(pkt_ready_ff, 32'h0000_0000);
  endtask
  task automatic t_retry;
    retry_time = 16'h0003;
    tx_fail = 1'b1;
    step(1);
    tx_fail = 1'b0;
    chk(retry_ok_ff, 32'h0000_0000);
    step(15);
    chk(retry_ok_ff, 32'h0000_0000);
    for (int i = 0; i < 60 && retry_ok_ff !== 1'b1; i++) step(1);
    chk(retry_ok_ff, 32'h0000_0001);
  endtask
  task automatic t_lim;
    {bufs_used, multidrop, node_count, drive_mode} = {5'h10, 1'b1, 8'h01, 2'h3};
    step(2);
    chk({buf_avail, cfg_err_ff, drv_en_ff, rx_en_ff}, 32'h0000_0005);
    {bufs_used, multidrop} = {5'h0F, 1'b0};
    step(2);
    chk({buf_avail, cfg_err_ff}, 32'h0000_0002);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {drive_mode, use_crc, echo_en, gateway_mode, highlight_en, multidrop, time_slice} = '0;
    {route_last, route_prev, appendix_present, replace_en, options, single_thread} = '0;
    {req_write, tx_fail, reply_start, reply_end, bufs_used, pkt_rd_addr, cfg_load} = '0;
    {stop2_in, sys_clk, arst_n, failures, cmp_count, cyc} = '0;
    {baud_in, parity_in, data8_in, buf_limit_in, stream_mode} = {32'h8, 2'h1, 1'b1, 5'h10, 1'b1};
    {pkt_size, pkt_time, ctrl_term, node_count, node_prio} = {8'h8, 16'h64, 1'b1, 8'h2, 8'h1};
    {fc_read_in, fc_write_in, retry_time, reg_bias, src_reg} = {8'h4, 8'h10, 16'h64, 16'h1, 16'h1};
    drop_in = 8'h02;
    step(5);
    arst_n = 1'b1;
    step(1);
    t_cfg;
    t_addr;
    t_route;
    dev.send(8'h41);
    dev.send(8'h42);
    dev.send(8'h0D);
    t_pkt(8'h03, 8'h41);
    pkt_size = 8'h02;
    dev.send(8'h78);
    dev.send(8'h79);
    t_pkt(8'h02, 8'h78);
    {pkt_size, pkt_time} = {8'h08, 16'h0014};
    dev.send(8'h5A);
    t_pkt(8'h01, 8'h5A);
    t_retry;
    t_lim;
    complete_run;
  end
endmodule // spcfg_port_tb_top
`default_nettype wire
